// *** common/crce_pkg.sv ***
/*
  Constants, types and register map of the byte-stream crc engine.
  Assumes a single 40 MHz system clock shared with the core's register port.
*/
package crce_pkg;
  localparam logic [7:0] ADDR_RESULT_PORT = 8'h91;
  localparam logic [7:0] ADDR_CONTROL = 8'h92;
  localparam logic [7:0] ADDR_DATA_INPUT = 8'h93;
  localparam logic [7:0] ADDR_BIT_REVERSE = 8'h95;
  localparam logic [7:0] ADDR_AUTO_CONTROL = 8'h96;
  localparam logic [7:0] ADDR_SECTOR_COUNT = 8'h97;

  localparam int CTL_POLY_SEL = 4;
  localparam int CTL_INIT = 3;
  localparam int CTL_INIT_VAL = 2;
  localparam int AUTO_EN_BIT = 7;
  localparam int AUTO_DONE_BIT = 6;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] AUTO_CONTROL_RESET = 8'h40;
  localparam logic [31:0] RESULT_RESET = 32'h00000000;
  localparam logic [5:0] SECTOR_COUNT_RESET = 6'h00;
  localparam logic [7:0] BIT_REVERSE_RESET = 8'h00;
  localparam logic [31:0] INIT_ONES = 32'hFFFFFFFF;
  localparam logic [15:0] POLY16 = 16'h1021;
  localparam logic [31:0] POLY32_REFLECTED = 32'hEDB88320;

  localparam int SECTOR_SHIFT = 9;
  localparam int SECTOR_BYTES = 512;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 8;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } crce_sfr_req_t;

  typedef enum logic [0:0] {
    AUTO_IDLE,
    AUTO_RUN
  } crce_auto_state_t;
endpackage : crce_pkg

// *** design/crce_engine.sv ***
/*
  Byte-stream crc engine with indirect result access, bit reverse register
  and an automatic flash sector walk fed through a 16-byte fifo.
  Assumes the core's register port and the flash read port run on i_clk_sys.
*/
`timescale 1ns/100ps

module crce_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] fill;
  logic push;
  logic pop;

  assign o_in_ready = (fill != (AW+1)'(DEPTH));
  assign o_out_valid = (fill != '0);
  assign o_out_data = mem[rd_idx];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk_sys) begin
    if (i_ce && push) begin
      mem[wr_idx] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset || (i_ce && i_flush)) begin
      wr_idx <= '0;
      rd_idx <= '0;
      fill <= '0;
    end else if (i_ce) begin
      if (push) begin
        wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : crce_fifo

module crce_engine
  import crce_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire crce_sfr_req_t i_sfr,
  output logic [7:0] o_sfr_rdata,
  output logic o_cpu_stall,
  output logic o_flash_rd,
  output logic [15:0] o_flash_addr,
  input wire logic i_flash_rdy,
  input wire logic [7:0] i_flash_data
);
  logic [31:0] result;
  logic poly_select;
  logic init_value_select;
  logic [1:0] result_byte_pointer;
  logic auto_enable;
  logic [5:0] start_sector;
  logic [5:0] sector_count;
  logic [7:0] bit_reverse_reg;
  crce_auto_state_t auto_state;
  logic [14:0] fetch_left;
  logic [14:0] fold_left;
  logic [15:0] fetch_addr;

  logic wr_ctrl;
  logic wr_input;
  logic wr_port;
  logic rd_port;
  logic [1:0] byte_sel;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic start_auto;
  logic [31:0] next_result;

  // one fold of a byte; upper half untouched in 16-bit mode
  function automatic logic [31:0] fold_byte(input logic [31:0] acc, input logic [7:0] din,
                                            input logic sel16);
    logic [31:0] a;
    logic [15:0] h;
    h = acc[15:0] ^ {din, 8'h00};
    for (int i = 0; i < 8; i++) begin
      if (h[15]) begin
        h = {h[14:0], 1'b0} ^ POLY16;
      end else begin
        h = {h[14:0], 1'b0};
      end
    end
    a = acc ^ {24'h000000, din};
    for (int i = 0; i < 8; i++) begin
      if (a[0]) begin
        a = {1'b0, a[31:1]} ^ POLY32_REFLECTED;
      end else begin
        a = {1'b0, a[31:1]};
      end
    end
    fold_byte = sel16 ? {acc[31:16], h} : a;
  endfunction : fold_byte

  assign wr_ctrl = i_sfr.wr && (i_sfr.addr == ADDR_CONTROL);
  assign wr_input = i_sfr.wr && (i_sfr.addr == ADDR_DATA_INPUT);
  assign wr_port = i_sfr.wr && (i_sfr.addr == ADDR_RESULT_PORT);
  assign rd_port = i_sfr.rd && (i_sfr.addr == ADDR_RESULT_PORT);
  // 16-bit mode aliases pointer bit 1 away
  assign byte_sel = {result_byte_pointer[1] && !poly_select, result_byte_pointer[0]};
  assign start_auto = wr_ctrl && auto_enable && (auto_state == AUTO_IDLE);
  assign o_cpu_stall = (auto_state == AUTO_RUN);
  // flash is only asked while the fifo has room
  assign o_flash_rd = (auto_state == AUTO_RUN) && (fetch_left != '0) && fifo_in_ready;
  assign o_flash_addr = fetch_addr;
  assign fifo_out_ready = (auto_state == AUTO_RUN);

  crce_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_flush(start_auto),
    .i_in_valid(o_flash_rd && i_flash_rdy),
    .o_in_ready(fifo_in_ready),
    .i_in_data(i_flash_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data)
  );

  always_comb begin
    next_result = result;
    if (wr_ctrl && i_sfr.wdata[CTL_INIT]) begin
      next_result = i_sfr.wdata[CTL_INIT_VAL] ? INIT_ONES : RESULT_RESET;
    end else if (wr_input) begin
      next_result = fold_byte(result, i_sfr.wdata, poly_select);
    end else if (wr_port) begin
      next_result[byte_sel*8 +: 8] = i_sfr.wdata;
    end else if (fifo_out_valid && fifo_out_ready) begin
      next_result = fold_byte(result, fifo_out_data, poly_select);
    end
  end

  // result updated in the write cycle's edge, so the next read already sees it
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      result <= RESULT_RESET;
    end else if (i_ce) begin
      result <= next_result;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      poly_select <= CONTROL_RESET[CTL_POLY_SEL];
      init_value_select <= CONTROL_RESET[CTL_INIT_VAL];
      result_byte_pointer <= CONTROL_RESET[1:0];
    end else if (i_ce) begin
      if (wr_ctrl) begin
        poly_select <= i_sfr.wdata[CTL_POLY_SEL];
        init_value_select <= i_sfr.wdata[CTL_INIT_VAL];
        result_byte_pointer <= i_sfr.wdata[1:0];
      end else if (wr_port || rd_port) begin
        result_byte_pointer <= result_byte_pointer + 2'h1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      auto_enable <= AUTO_CONTROL_RESET[AUTO_EN_BIT];
      start_sector <= AUTO_CONTROL_RESET[5:0];
      sector_count <= SECTOR_COUNT_RESET;
      bit_reverse_reg <= BIT_REVERSE_RESET;
    end else if (i_ce && i_sfr.wr) begin
      if (i_sfr.addr == ADDR_AUTO_CONTROL) begin
        auto_enable <= i_sfr.wdata[AUTO_EN_BIT];
        start_sector <= i_sfr.wdata[5:0];
      end
      if (i_sfr.addr == ADDR_SECTOR_COUNT) begin
        sector_count <= i_sfr.wdata[5:0];
      end
      if (i_sfr.addr == ADDR_BIT_REVERSE) begin
        bit_reverse_reg <= {<<{i_sfr.wdata}};
      end
    end
  end

  // a zero sector count starts nothing, so the core is never held needlessly
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      auto_state <= AUTO_IDLE;
      fetch_left <= '0;
      fold_left <= '0;
      fetch_addr <= '0;
    end else if (i_ce) begin
      case (auto_state)
        AUTO_IDLE: begin
          if (start_auto && (sector_count != '0)) begin
            auto_state <= AUTO_RUN;
            fetch_left <= {sector_count, 9'h000};
            fold_left <= {sector_count, 9'h000};
            fetch_addr <= {1'b0, start_sector, 9'h000};
          end
        end
        AUTO_RUN: begin
          if (o_flash_rd && i_flash_rdy) begin
            fetch_left <= fetch_left - 15'h0001;
            fetch_addr <= fetch_addr + 16'h0001;
          end
          if (fifo_out_valid) begin
            fold_left <= fold_left - 15'h0001;
            if (fold_left == 15'h0001) begin
              auto_state <= AUTO_IDLE;
            end
          end
        end
        default: auto_state <= AUTO_IDLE;
      endcase
    end
  end

  always_comb begin
    case (i_sfr.addr)
      ADDR_RESULT_PORT: o_sfr_rdata = result[byte_sel*8 +: 8];
      ADDR_CONTROL: o_sfr_rdata = {3'b000, poly_select, 1'b0, init_value_select,
                                   result_byte_pointer};
      ADDR_BIT_REVERSE: o_sfr_rdata = bit_reverse_reg;
      ADDR_AUTO_CONTROL: o_sfr_rdata = {auto_enable, auto_state == AUTO_IDLE,
                                        start_sector};
      ADDR_SECTOR_COUNT: o_sfr_rdata = {2'b00, sector_count};
      default: o_sfr_rdata = 8'h00;
    endcase
  end

  init_load_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_ce && wr_ctrl && i_sfr.wdata[CTL_INIT] |=>
      result == (($past(i_sfr.wdata[CTL_INIT_VAL])) ? INIT_ONES : RESULT_RESET))
    else $error("init did not load result");

  vector16_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_ce && wr_input && poly_select && result[15:0] == 16'hFFFF && i_sfr.wdata == 8'h63
      |=> result[15:0] == 16'hBD35)
    else $error("16-bit reference vector mismatch");

  vector32_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_ce && wr_input && !poly_select && result == INIT_ONES && i_sfr.wdata == 8'h63
      |=> result == 32'hF9462090)
    else $error("32-bit reference vector mismatch");

  pointer_step_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_ce && rd_port |=> result_byte_pointer == $past(result_byte_pointer) + 2'h1)
    else $error("pointer did not advance");

  result_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !(i_ce && (wr_ctrl || wr_input || wr_port || (fifo_out_valid && fifo_out_ready)))
      |=> $stable(result))
    else $error("result changed without cause");

  alias16_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    poly_select && i_sfr.addr == ADDR_RESULT_PORT |->
      o_sfr_rdata == (result_byte_pointer[0] ? result[15:8] : result[7:0]))
    else $error("16-bit pointer alias wrong");

  unused_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_sfr.addr == ADDR_CONTROL |-> o_sfr_rdata[7:5] == 3'b000)
    else $error("control unused bits nonzero");

  auto_start_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_ce && start_auto && sector_count != '0 |=> o_cpu_stall && fold_left ==
      15'(SECTOR_BYTES) * 15'($past(sector_count)))
    else $error("automatic run did not start");

  done_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_sfr.addr == ADDR_AUTO_CONTROL |-> o_sfr_rdata[AUTO_DONE_BIT] == !o_cpu_stall)
    else $error("completion flag disagrees with stall");

  flip_read_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_ce && i_sfr.wr && i_sfr.addr == ADDR_BIT_REVERSE ##1 i_sfr.addr == ADDR_BIT_REVERSE
      |-> $past(i_sfr.wdata) == {o_sfr_rdata[0], o_sfr_rdata[1], o_sfr_rdata[2],
        o_sfr_rdata[3], o_sfr_rdata[4], o_sfr_rdata[5], o_sfr_rdata[6], o_sfr_rdata[7]})
    else $error("bit reverse readback wrong");
endmodule : crce_engine

// *** verification/crce_flash_model.sv ***
/*
  Flash read port model standing behind the crc engine's sector walk.
  Assumes requests are sampled on rising edges of i_clk_sys.
*/
`timescale 1ns/100ps
module crce_flash_model #(
  parameter int SLOW = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_flash_rd,
  input wire logic [15:0] i_flash_addr,
  output logic o_flash_rdy,
  output logic [7:0] o_flash_data
);
  logic [1:0] beat;
  logic [7:0] last;
  // slow mode refuses one beat in four, so the fifo sees gaps
  assign o_flash_rdy = !(SLOW != 0 && beat == 2'h3);
  // outside a transfer the stale byte is inverted, never left showing
  assign o_flash_data = (i_flash_rd && o_flash_rdy) ?
    (i_flash_addr[7:0] ^ i_flash_addr[15:8] ^ 8'h5A) : ~last;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      beat <= 2'h0;
      last <= 8'h00;
    end else begin
      beat <= beat + 2'h1;
      if (i_flash_rd && o_flash_rdy) begin
        last <= o_flash_data;
      end
    end
  end
endmodule : crce_flash_model

// *** verification/tb.sv ***
/*
  Self-checking bench for the crc engine: register accesses, both modes, sector walk.
  Assumes the flash model answers on the engine's flash port.
*/
`timescale 1ns/100ps
module tb;
  import crce_pkg::*;
  logic i_clk_sys;
  logic i_reset;
  logic i_ce;
  crce_sfr_req_t i_sfr;
  logic [7:0] o_sfr_rdata;
  logic o_cpu_stall;
  logic o_flash_rd;
  logic [15:0] o_flash_addr;
  logic flash_rdy;
  logic [7:0] flash_data;
  int errors = 0;
  int samples_checked = 0;
  int fetched = 0;
  int n;
  logic [31:0] expect_crc;
  logic [7:0] seq [3] = '{8'hAA, 8'hBB, 8'hCC};
  logic [7:0] flip_in [3] = '{8'hC0, 8'h01, 8'h12};
  logic [7:0] flip_out [3] = '{8'h03, 8'h80, 8'h48};

  crce_engine i_crce_engine (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(i_ce),
    .i_sfr(i_sfr), .o_sfr_rdata(o_sfr_rdata), .o_cpu_stall(o_cpu_stall),
    .o_flash_rd(o_flash_rd), .o_flash_addr(o_flash_addr), .i_flash_rdy(flash_rdy),
    .i_flash_data(flash_data));
  crce_flash_model #(.SLOW(1)) i_crce_flash_model (.i_clk_sys(i_clk_sys),
    .i_reset(i_reset), .i_flash_rd(o_flash_rd), .i_flash_addr(o_flash_addr),
    .o_flash_rdy(flash_rdy), .o_flash_data(flash_data));

  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // one access per cycle; the next call or idle() replaces the strobe
  task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d,
                        input logic [7:0] exp);
    @(negedge i_clk_sys);
    i_sfr = '{addr: a, wr: w, rd: !w, wdata: d};
    #1;
    if (!w) begin
      check(o_sfr_rdata, exp);
    end
  endtask : access

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    access(a, 1'b1, d, 8'h00);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    access(a, 1'b0, 8'h00, exp);
  endtask : rd

  task automatic idle(input logic [7:0] a);
    @(negedge i_clk_sys);
    i_sfr = '{addr: a, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
    #1;
  endtask : idle

  task automatic rd_res(input logic [31:0] val, input logic s16);
    for (int p = 0; p < 4; p++) begin
      rd(ADDR_RESULT_PORT, s16 ? val[8 * p[0] +: 8] : val[8 * p +: 8]);
    end
  endtask : rd_res

  task automatic feed3();
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_DATA_INPUT, seq[k]);
    end
  endtask : feed3

  function automatic logic [31:0] fold32(input logic [31:0] acc, input logic [7:0] b);
    logic [31:0] a;
    a = acc ^ {24'h0, b};
    for (int i = 0; i < 8; i++) begin
      a = a[0] ? ((a >> 1) ^ POLY32_REFLECTED) : (a >> 1);
    end
    return a;
  endfunction : fold32

  // every accepted fetch must be the next byte of the walk
  always @(negedge i_clk_sys) begin
    if (o_flash_rd === 1'b1 && flash_rdy === 1'b1) begin
      check({16'h0, o_flash_addr}, 32'h200 + fetched);
      fetched <= fetched + 1;
    end
  end

  initial begin
    #2000000;
    errors++;
    give_verdict();
  end

  initial begin
    i_reset = 1'b1;
    i_ce = 1'b1;
    i_sfr = '0;
    repeat (8) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_reset = 1'b0;
    @(posedge i_clk_sys);
    rd(ADDR_CONTROL, CONTROL_RESET);
    rd(ADDR_AUTO_CONTROL, 8'h40);
    rd(ADDR_SECTOR_COUNT, 8'h00);
    rd(8'h90, 8'h00);
    wr(ADDR_CONTROL, 8'hE8);
    rd(ADDR_CONTROL, 8'h00);
    rd_res(32'h0, 1'b0);
    wr(ADDR_CONTROL, 8'h0C);
    wr(ADDR_DATA_INPUT, 8'h63);
    rd_res(32'hF9462090, 1'b0);
    wr(ADDR_CONTROL, 8'h0C);
    feed3();
    rd_res(32'h41B207B3, 1'b0);
    // a write with the clock enable low must leave the result alone
    @(negedge i_clk_sys);
    i_ce = 1'b0;
    i_sfr = '{addr: ADDR_DATA_INPUT, wr: 1'b1, rd: 1'b0, wdata: 8'h11};
    @(negedge i_clk_sys);
    i_ce = 1'b1;
    i_sfr = '0;
    rd_res(32'h41B207B3, 1'b0);
    wr(ADDR_CONTROL, 8'h1C);
    wr(ADDR_DATA_INPUT, 8'h63);
    rd_res(32'hBD35, 1'b1);
    wr(ADDR_CONTROL, 8'h1C);
    feed3();
    rd_res(32'h6CF6, 1'b1);
    wr(ADDR_CONTROL, 8'h02);
    wr(ADDR_RESULT_PORT, 8'hA5);
    wr(ADDR_RESULT_PORT, 8'h5A);
    wr(ADDR_RESULT_PORT, 8'h3C);
    wr(ADDR_RESULT_PORT, 8'hC3);
    wr(ADDR_CONTROL, 8'h00);
    rd_res(32'h5AA5C33C, 1'b0);
    for (n = 0; n < 3; n++) begin
      wr(ADDR_BIT_REVERSE, flip_in[n]);
      rd(ADDR_BIT_REVERSE, flip_out[n]);
    end
    wr(ADDR_SECTOR_COUNT, 8'hFF);
    rd(ADDR_SECTOR_COUNT, 8'h3F);
    wr(ADDR_AUTO_CONTROL, 8'h3F);
    rd(ADDR_AUTO_CONTROL, 8'h7F);
    wr(ADDR_CONTROL, 8'h0C);
    wr(ADDR_AUTO_CONTROL, 8'h01);
    wr(ADDR_AUTO_CONTROL, 8'h81);
    wr(ADDR_SECTOR_COUNT, 8'h01);
    wr(ADDR_CONTROL, 8'h0C);
    idle(ADDR_AUTO_CONTROL);
    check(o_cpu_stall, 32'h1);
    check(o_flash_addr, 32'h200);
    check(o_sfr_rdata[AUTO_DONE_BIT], 32'h0);
    n = 0;
    while (o_cpu_stall !== 1'b0 && n < 3000) begin
      @(negedge i_clk_sys);
      n++;
    end
    if (n >= 3000) begin
      errors++;
      give_verdict();
    end
    check(fetched, 32'd512);
    expect_crc = INIT_ONES;
    for (n = 512; n < 1024; n++) begin
      expect_crc = fold32(expect_crc, n[7:0] ^ n[15:8] ^ 8'h5A);
    end
    wr(ADDR_BIT_REVERSE, 8'h5A);
    rd(ADDR_AUTO_CONTROL, 8'hC1);
    wr(ADDR_AUTO_CONTROL, 8'h01);
    rd_res(expect_crc, 1'b0);
    idle(8'h00);
    give_verdict();
  end
endmodule : tb
